// [hw/pif_pkg.sv]
// Shared constants and carriers for the peripheral interrupt flag block.
// Assumes one core clock; all event sources run on that same clock.
package pif_pkg;

   // Register port widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets (word index on the plain register port)
   localparam logic [ADDR_W-1:0] OFS_FLAGS1 = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_FLAGS2 = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_MASK1 = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_MASK2 = 4'h3;

   // First flag bank field positions
   localparam int F1_TIMER1_GATE = 7;
   localparam int F1_CONVERTER_DONE = 6;
   localparam int F1_SERIAL_RECEIVE = 5;
   localparam int F1_SERIAL_TRANSMIT = 4;
   localparam int F1_SYNC_PORT1 = 3;
   localparam int F1_CAPTURE_COMPARE1 = 2;
   localparam int F1_TIMER2_MATCH = 1;
   localparam int F1_TIMER1_OVERFLOW = 0;

   // Second flag bank field positions
   localparam int F2_OSCILLATOR_FAIL = 7;
   localparam int F2_COMPARATOR2 = 6;
   localparam int F2_COMPARATOR1 = 5;
   localparam int F2_EEPROM_WRITE_DONE = 4;
   localparam int F2_SYNC_PORT1_COLLISION = 3;
   localparam int F2_CAPTURE_COMPARE2 = 0;

   // Bits of bank 1 that software may write; the rest follow their source
   localparam logic [DATA_W-1:0] F1_SW_MASK = 8'hcf;
   // Implemented bits of bank 2 on the larger variant
   localparam logic [DATA_W-1:0] F2_IMPL_MASK = 8'hf9;
   // Reset values
   localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;

   // One register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pif_bus_req_s;

   // Event inputs of both banks, one bit per flag position
   typedef struct packed {
      logic [DATA_W-1:0] bank1;
      logic [DATA_W-1:0] bank2;
   } pif_events_s;

endpackage

// [hw/pif_flags.sv]
// Two banks of peripheral interrupt request flags with masks and one
// level interrupt output. Register port: one-cycle strobes, read data
// one cycle after the read strobe. Event sources share the core clock.
//
// Behaviour
// - Source events set flags regardless of enables
// - Bank 1 bit layout fixed, gate to overflow
// - Serial receive/transmit flags read-only, follow source
// - All flags reset to zero on reset
// - Bank 2 layout fixed, implemented bits read/write
// - Bank 2 bits 2-1 read zero, ignore writes
// - Flag reads one while pending, else zero
// - Capture/compare 2 flag only on larger variant
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps

module pif_flags
   import pif_pkg::*;
#(
   parameter bit HAS_CAPTURE_COMPARE2 = 1'b1 // Larger variant carries capture/compare 2
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire pif_bus_req_s i_bus,
   input wire pif_events_s i_events,
   output logic [DATA_W-1:0] o_rdata,
   output logic [DATA_W-1:0] o_flags1,
   output logic [DATA_W-1:0] o_flags2,
   output logic o_irq
);

   // Implemented bits of bank 2 for this variant
   localparam logic [DATA_W-1:0] F2_MASK = HAS_CAPTURE_COMPARE2 ? F2_IMPL_MASK :
      (F2_IMPL_MASK & ~(8'h01 << F2_CAPTURE_COMPARE2));

   // Flag banks and interrupt masks
   logic [DATA_W-1:0] flags1; // Bank 1 request flags
   logic [DATA_W-1:0] flags2; // Bank 2 request flags
   logic [DATA_W-1:0] mask1; // Bank 1 interrupt mask
   logic [DATA_W-1:0] mask2; // Bank 2 interrupt mask
   logic [DATA_W-1:0] next_flags1; // Bank 1 value after this edge
   logic [DATA_W-1:0] next_flags2; // Bank 2 value after this edge
   logic irq_bank1; // Any unmasked bank 1 flag pending
   logic irq_bank2; // Any unmasked bank 2 flag pending

   // Write strobes decoded per register
   logic wr_flags1;
   logic wr_flags2;
   logic wr_mask1;
   logic wr_mask2;

   // Address decode for writes
   always_comb begin
      wr_flags1 = i_bus.wr && (i_bus.addr == OFS_FLAGS1);
      wr_flags2 = i_bus.wr && (i_bus.addr == OFS_FLAGS2);
      wr_mask1 = i_bus.wr && (i_bus.addr == OFS_MASK1);
      wr_mask2 = i_bus.wr && (i_bus.addr == OFS_MASK2);
   end

   // Next flag values: software write first, then events OR in on top.
   // OR-ing last is what lets a coincident event beat a clearing write.
   // Writing a one also sets a writable flag, so software can raise a
   // request by hand; the serial pair can never be forced that way.
   always_comb begin
      // Writable bits of bank 1 take the write or hold
      next_flags1 = (wr_flags1 ? i_bus.wdata : flags1) | i_events.bank1;
      next_flags1 = next_flags1 & F1_SW_MASK;
      // Serial flags simply mirror their source level
      next_flags1 = next_flags1 | (i_events.bank1 & ~F1_SW_MASK);
      // Bank 2: same scheme, unimplemented bits forced low
      next_flags2 = (wr_flags2 ? i_bus.wdata : flags2) | i_events.bank2;
      next_flags2 = next_flags2 & F2_MASK;
   end

   // Bank 1 flag storage
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flags1 <= FLAGS_RESET;
      end else begin
         flags1 <= next_flags1;
      end
   end

   // Bank 2 flag storage
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flags2 <= FLAGS_RESET;
      end else begin
         flags2 <= next_flags2;
      end
   end

   // Mask registers; only real flag positions can be enabled
   // A set mask bit lets its flag drive the interrupt output
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask1 <= MASK_RESET;
         mask2 <= MASK_RESET;
      end else begin
         // Each mask written on its own offset
         if (wr_mask1) begin
            mask1 <= i_bus.wdata;
         end
         if (wr_mask2) begin
            mask2 <= i_bus.wdata & F2_MASK;
         end
      end
   end

   // Read data: valid only in the cycle after the strobe, zero otherwise.
   // Unmapped offsets answer zero so software never sees stale data.
   // Software sees the state of the strobe cycle; an event landing in that
   // same cycle shows up on the next read instead.
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            OFS_FLAGS1: o_rdata <= flags1;
            OFS_FLAGS2: o_rdata <= flags2;
            OFS_MASK1: o_rdata <= mask1;
            OFS_MASK2: o_rdata <= mask2;
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // Flags go straight out to the processor interrupt logic
   assign o_flags1 = flags1;
   assign o_flags2 = flags2;

   // Level interrupt: any unmasked pending flag. Software is expected to
   // clear stale flags before unmasking, or this fires at once; the block
   // cannot tell a stale flag from a fresh one, so it does not try.
   assign irq_bank1 = |(flags1 & mask1);
   assign irq_bank2 = |(flags2 & mask2);
   assign o_irq = irq_bank1 || irq_bank2;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Every check shares the core clock and rests while reset is held,
   // since every register is forced to its reset value there anyway.
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   // An event on a writable bit is set next cycle, even under a clear
   property p_set_wins;
      (i_events.bank1 & F1_SW_MASK) != '0 |=>
         ((flags1 & $past(i_events.bank1) & F1_SW_MASK) ==
         ($past(i_events.bank1) & F1_SW_MASK));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost under a clearing write");

   // A bank 1 write stores the written bits plus any events
   property p_write1;
      wr_flags1 |=> ((flags1 & F1_SW_MASK) ==
         (($past(i_bus.wdata) | $past(i_events.bank1)) & F1_SW_MASK));
   endproperty
   a_write1: assert property (p_write1)
      else $error("bank 1 write not stored");

   // Serial flags follow their source only, never the write data
   property p_serial_ro;
      wr_flags1 ##1 1'b1 |-> (flags1[F1_SERIAL_RECEIVE:F1_SERIAL_TRANSMIT] ==
         $past(i_events.bank1[F1_SERIAL_RECEIVE:F1_SERIAL_TRANSMIT]));
   endproperty
   a_serial_ro: assert property (p_serial_ro)
      else $error("serial flag took write data");

   // After a bank 2 read strobe, unimplemented bank 2 bits are low and read back zero
   property p_unimpl;
      (i_bus.rd && i_bus.addr == OFS_FLAGS2) |=> (o_rdata[2:1] == 2'b00) && (flags2[2:1] == 2'b00);
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented bank 2 bit set");

   // Read returns the flag state of the strobe cycle
   property p_read1;
      (i_bus.rd && i_bus.addr == OFS_FLAGS1) |=> (o_rdata == $past(flags1));
   endproperty
   a_read1: assert property (p_read1)
      else $error("bank 1 read mismatch");

   // First edge after reset release shows empty banks
   property p_reset;
      $rose(i_reset_n) |-> (flags1 == FLAGS_RESET) && (flags2 == FLAGS_RESET);
   endproperty
   a_reset: assert property (p_reset)
      else $error("flags not clear after reset");

   // Timer1 gate event lands at bit 7 and is still set one cycle later unless cleared
   property p_bank1_pos;
      (i_events.bank1[F1_TIMER1_GATE] && !wr_flags1) |=> flags1[F1_TIMER1_GATE] ##1
         (flags1[F1_TIMER1_GATE] || $past(wr_flags1));
   endproperty
   a_bank1_pos: assert property (p_bank1_pos)
      else $error("timer1 gate flag misplaced");

   // Oscillator fail and collision events land at bits 7 and 3
   property p_bank2_pos;
      (i_events.bank2[F2_OSCILLATOR_FAIL] && i_events.bank2[F2_SYNC_PORT1_COLLISION]) |=>
         flags2[F2_OSCILLATOR_FAIL] && flags2[F2_SYNC_PORT1_COLLISION];
   endproperty
   a_bank2_pos: assert property (p_bank2_pos)
      else $error("bank 2 flag misplaced");

   // Smaller variant never shows capture/compare 2
   property p_variant;
      !HAS_CAPTURE_COMPARE2 |-> !flags2[F2_CAPTURE_COMPARE2];
   endproperty
   a_variant: assert property (p_variant)
      else $error("capture/compare 2 flag on small variant");

   // Interrupt follows unmasked flags; event on unmasked bank 2 bit raises it
   property p_irq;
      (i_events.bank2 & mask2 & F2_MASK) != '0 && !wr_mask2 |=> o_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked event did not interrupt");

   // An event on an unmasked bank 1 bit raises the interrupt next cycle
   property p_irq1;
      ((i_events.bank1 & mask1) != '0) && !wr_mask1 |=> o_irq;
   endproperty
   a_irq1: assert property (p_irq1)
      else $error("unmasked bank 1 event did not interrupt");

   // Bank 2 events survive a coincident clearing write as well
   property p_set_wins2;
      (i_events.bank2 & F2_MASK) != '0 |=>
         ((flags2 & $past(i_events.bank2) & F2_MASK) == ($past(i_events.bank2) & F2_MASK));
   endproperty
   a_set_wins2: assert property (p_set_wins2)
      else $error("bank 2 event lost under a clearing write");

   // A bank 2 write stores the written bits plus any events, masked to
   // the positions this variant implements
   property p_write2;
      wr_flags2 |=> (flags2 == (($past(i_bus.wdata) | $past(i_events.bank2)) & F2_MASK));
   endproperty
   a_write2: assert property (p_write2)
      else $error("bank 2 write not stored");

   // Without a write, a pending writable bank 1 flag stays until software clears it
   property p_hold1;
      !wr_flags1 |=> ((flags1 & F1_SW_MASK) ==
         (($past(flags1) | $past(i_events.bank1)) & F1_SW_MASK));
   endproperty
   a_hold1: assert property (p_hold1)
      else $error("bank 1 flag changed without write or event");

   // Same for bank 2
   property p_hold2;
      !wr_flags2 |=> (flags2 == (($past(flags2) | $past(i_events.bank2)) & F2_MASK));
   endproperty
   a_hold2: assert property (p_hold2)
      else $error("bank 2 flag changed without write or event");

   // Read returns the bank 2 state of the strobe cycle
   property p_read2;
      (i_bus.rd && i_bus.addr == OFS_FLAGS2) |=> (o_rdata == $past(flags2));
   endproperty
   a_read2: assert property (p_read2)
      else $error("bank 2 read mismatch");

   // Read data fall back to zero when no read was made, so a late sampler
   // sees zero rather than an old value
   property p_rdata_idle;
      !i_bus.rd |=> (o_rdata == '0);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data held without a read");

   // Bank 2 mask keeps only the implemented positions
   property p_mask2;
      wr_mask2 |=> (mask2 == ($past(i_bus.wdata) & F2_MASK));
   endproperty
   a_mask2: assert property (p_mask2)
      else $error("bank 2 mask took an unimplemented bit");

   // Serial flags track their source level on every edge, written or not
   property p_serial_follow;
      1'b1 |=> (flags1[F1_SERIAL_RECEIVE:F1_SERIAL_TRANSMIT] ==
         $past(i_events.bank1[F1_SERIAL_RECEIVE:F1_SERIAL_TRANSMIT]));
   endproperty
   a_serial_follow: assert property (p_serial_follow)
      else $error("serial flag does not follow its source");

   // Masks and read data also leave reset empty, so no interrupt at start
   property p_reset_rest;
      $rose(i_reset_n) |-> (mask1 == MASK_RESET) && (mask2 == MASK_RESET) &&
         (o_rdata == '0) && !o_irq;
   endproperty
   a_reset_rest: assert property (p_reset_rest)
      else $error("mask or read data not clear after reset");

   // Main scenarios
   c_clear_vs_set: cover property (wr_flags1 && (i_events.bank1 & ~i_bus.wdata & F1_SW_MASK) != '0);
   c_irq_rise: cover property ($rose(o_irq));
   c_clear_irq: cover property (o_irq ##1 wr_flags2 ##1 !o_irq);
   c_serial_level: cover property ($rose(flags1[F1_SERIAL_RECEIVE]));
   c_read_back: cover property (i_bus.rd ##1 (o_rdata != '0));

endmodule

// [tb/pif_src_model.sv]
// Behavioural event sources facing the flag block.
// Assumes the bench requests pulses on the core clock.
`timescale 1ns/100ps
module pif_src_model
   import pif_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_pulse1, // Bank 1 pulse requests
   input wire logic [7:0] i_pulse2, // Bank 2 pulse requests
   input wire logic [1:0] i_serial, // Receive/transmit pending levels
   output pif_events_s o_events
);
   // One-cycle pulses; serial sources are levels, so never pulsed
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_events <= '0;
      end else begin
         o_events.bank1 <= (i_pulse1 & 8'hcf) | {2'b00, i_serial, 4'h0};
         o_events.bank2 <= i_pulse2;
      end
   end
endmodule

// [tb/tb.sv]
// Self-checking bench for the peripheral flag block.
// Assumes the source model and one 25 MHz core clock.
`timescale 1ns/100ps
module tb
   import pif_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   pif_bus_req_s bus = '0;
   logic [7:0] p1 = '0; // Pulse requests to the model
   logic [7:0] p2 = '0;
   logic [1:0] ser = '0; // Serial pending levels
   pif_events_s ev;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] flags1;
   logic [DATA_W-1:0] flags2;
   logic irq;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   // Rows: bank 1 pulses, bank 2 pulses, expected flags 1 and 2
   logic [7:0] rows [4][4] = '{'{8'hff, 8'hff, 8'hcf, 8'hf9},
      '{8'h80, 8'h01, 8'h80, 8'h01}, '{8'h41, 8'h06, 8'h41, 8'h00},
      '{8'h3e, 8'h78, 8'h0e, 8'h78}};

   pif_src_model i_pif_src_model (.i_core_clk(clk), .i_reset_n(reset_n),
      .i_pulse1(p1), .i_pulse2(p2), .i_serial(ser), .o_events(ev));
   pif_flags i_pif_flags (.i_core_clk(clk), .i_reset_n(reset_n), .i_bus(bus),
      .i_events(ev), .o_rdata(rdata), .o_flags1(flags1), .o_flags2(flags2),
      .o_irq(irq));

   initial begin
      forever #20 clk = ~clk;
   end

   // Cut a hang short; the whole run needs well under this
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Bus tasks are entered just after a rising edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      cmp(name, exp, rdata);
      @(posedge clk);
   endtask

   task automatic pulse(input logic [7:0] a, input logic [7:0] b);
      p1 <= a;
      p2 <= b;
      @(posedge clk);
      p1 <= '0;
      p2 <= '0;
      repeat (2) @(posedge clk);
   endtask

   // Level outputs are looked at mid-cycle, clear of the edge that moves them
   task automatic cmp_irq(input string name, input logic exp);
      @(negedge clk);
      cmp(name, {7'h0, exp}, {7'h0, irq});
      @(posedge clk);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(OFS_FLAGS1, 8'h00, "flags1 reset");
      rd(OFS_FLAGS2, 8'h00, "flags2 reset");
      rd(OFS_MASK1, 8'h00, "mask1 reset");
      // Masks stay off, so flags must set with enables clear
      for (int i = 0; i < 4; i++) begin
         wr(OFS_FLAGS1, 8'h00);
         wr(OFS_FLAGS2, 8'h00);
         pulse(rows[i][0], rows[i][1]);
         rd(OFS_FLAGS1, rows[i][2], "flags1");
         rd(OFS_FLAGS2, rows[i][3], "flags2");
      end
      wr(OFS_FLAGS1, 8'hff);
      rd(OFS_FLAGS1, 8'hcf, "flags1 write");
      wr(OFS_FLAGS2, 8'hff);
      rd(OFS_FLAGS2, 8'hf9, "flags2 write");
      wr(OFS_FLAGS1, 8'h00);
      rd(OFS_FLAGS1, 8'h00, "flags1 clear");
      // Serial flags follow their level and ignore clearing writes
      ser <= 2'b11;
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp("flags1 serial", 8'h30, flags1);
      @(posedge clk);
      wr(OFS_FLAGS1, 8'h00);
      rd(OFS_FLAGS1, 8'h30, "flags1 serial write");
      ser <= 2'b00;
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp("flags1 serial off", 8'h00, flags1);
      @(posedge clk);
      // Event lands in the same cycle as the clearing write
      p1 <= 8'h04;
      @(posedge clk);
      p1 <= '0;
      wr(OFS_FLAGS1, 8'h00);
      rd(OFS_FLAGS1, 8'h04, "flags1 race");
      wr(OFS_FLAGS1, 8'h00);
      wr(OFS_MASK1, 8'h80);
      cmp_irq("irq idle", 1'b0);
      pulse(8'h80, 8'h00);
      cmp_irq("irq set", 1'b1);
      wr(OFS_MASK1, 8'h00);
      cmp_irq("irq masked", 1'b0);
      wr(OFS_MASK1, 8'h80);
      wr(OFS_FLAGS1, 8'h00);
      cmp_irq("irq cleared", 1'b0);
      wr(OFS_MASK2, 8'hff);
      rd(OFS_MASK2, 8'hf9, "mask2");
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00, "unmapped");
      pulse(8'h00, 8'h01);
      cmp_irq("irq bank2", 1'b1);
      // Reset in mid-run wipes pending flags and masks
      reset_n <= 1'b0;
      @(posedge clk);
      cmp("flags2 midreset", 8'h00, flags2);
      cmp("flags1 midreset", 8'h00, flags1);
      cmp_irq("irq midreset", 1'b0);
      // Second release: the block must take events and requests again
      reset_n <= 1'b1;
      @(posedge clk);
      rd(OFS_MASK2, 8'h00, "mask2 after reset");
      pulse(8'h01, 8'h10);
      rd(OFS_FLAGS1, 8'h01, "flags1 after reset");
      rd(OFS_FLAGS2, 8'h10, "flags2 after reset");
      finish_test();
   end
endmodule
